// ---- inc/usb_dma_select_pkg.sv ----
// Types of the DMA request select block
package usb_dma_select_pkg;

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [7:0] chan0_sel;
    logic [7:0] chan1_sel;
    logic [7:0] dir_enable;
    logic frame_deferred_ready;
    logic stale_packet_autoflush;
    logic [3:0] tx_ready;
    logic [3:0] flush_oldest;
    logic [1:0] dma_req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } select_state_t;

endpackage

// ---- inc/usb_dma_select_regs.svh ----
// Register indices, field positions and reset values of the DMA request select block
`ifndef USB_DMA_SELECT_REGS_SVH
`define USB_DMA_SELECT_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ISOCHRONOUS_CONTROL_IDX 14'h0308
`define DMA_CHANNEL0_REQUEST_SELECT_IDX 14'h0309
`define DMA_CHANNEL1_REQUEST_SELECT_IDX 14'h030A
`define ENDPOINT_DIRECTION_ENABLE_IDX 14'h030B
`define SELECT_STATUS_IDX 14'h030C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define REQUEST_SELECT_RESET 8'h00
`define ENDPOINT_DIRECTION_ENABLE_RESET 8'hFF
`define ISOCHRONOUS_CONTROL_RESET 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STALE_PACKET_AUTOFLUSH_BIT 6
`define FRAME_DEFERRED_READY_BIT 7
`define SEL_TX_LSB 0
`define SEL_RX_LSB 4
`define STATUS_DMA_REQ_LSB 4

`endif

// ---- src/usb_dma_select.sv ----
// USB isochronous controls, endpoint enables and DMA request routing behind APB
//
// Behaviour
// R01 - Bit 6 enables automatic IN FIFO flush
// R02 - One request select register per DMA channel
// R03 - Several select bits set forward nothing
// R04 - Bits 0-3 IN write, 4-7 OUT read
// R05 - Endpoint direction enables reset to all ones
// R06 - Iso control bits 5:0 read zero
// R07 - Deferred ready waits for next start-of-frame
// R08 - Start-of-frame with ready packet flushes oldest
// R09 - Max packet at most half FIFO size; the block does not check packet size
// R10 - Request forwarded only when direction enabled
`timescale 1ns/100ps
`default_nettype none
`include "usb_dma_select_regs.svh"

module usb_dma_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sof_pulse,
  input wire logic [3:0] ep_iso,
  input wire logic [3:0] tx_packet_loaded,
  input wire logic [3:0] ep_tx_write_req,
  input wire logic [3:0] ep_rx_read_req,
  output logic [3:0] tx_ready,
  output logic [3:0] tx_flush_oldest,
  output logic [1:0] dma_req
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Exactly one bit set
  function automatic logic one_hot(input logic [7:0] v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  // Route the selected endpoint request to one channel
  function automatic logic route(input logic [7:0] sel, input logic [7:0] en,
                                 input logic [3:0] txr, input logic [3:0] rxr);
    logic [3:0] tx_en;
    logic [3:0] rx_en;
    logic [7:0] cand;
    for (int i = 0; i < 4; i++) begin
      rx_en[i] = en[2*i];
      tx_en[i] = en[2*i+1];
    end
    cand = {rxr & rx_en, txr & tx_en}; // [R04] [R10]
    return one_hot(sel) && ((sel & cand) != 8'h00); // [R03]
  endfunction

  usb_dma_select_pkg::select_state_t st;
  usb_dma_select_pkg::select_state_t next_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Bus slave, iso readiness and request routing in one pass
  always_comb begin
    logic [13:0] widx;
    logic hit;
    logic [7:0] rdval;
    widx = paddr[15:2];
    hit = 1'b1;
    rdval = 8'h00;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    case (widx)
      `ISOCHRONOUS_CONTROL_IDX: begin
        rdval[`FRAME_DEFERRED_READY_BIT] = st.frame_deferred_ready; // [R06]
        rdval[`STALE_PACKET_AUTOFLUSH_BIT] = st.stale_packet_autoflush;
      end
      `DMA_CHANNEL0_REQUEST_SELECT_IDX: rdval = st.chan0_sel;
      `DMA_CHANNEL1_REQUEST_SELECT_IDX: rdval = st.chan1_sel;
      `ENDPOINT_DIRECTION_ENABLE_IDX: rdval = st.dir_enable;
      `SELECT_STATUS_IDX: rdval = {2'b00, st.dma_req, st.tx_ready};
      default: hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
    // One wait state keeps every bus output registered
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata = {24'h000000, hit ? rdval : 8'h00};
    end
    // Writes land on the edge that completes the transfer
    if (psel && penable && st.pready && pwrite && hit) begin
      case (widx)
        `ISOCHRONOUS_CONTROL_IDX: begin
          next_st.frame_deferred_ready = pwdata[`FRAME_DEFERRED_READY_BIT];
          next_st.stale_packet_autoflush = pwdata[`STALE_PACKET_AUTOFLUSH_BIT]; // [R01]
        end
        `DMA_CHANNEL0_REQUEST_SELECT_IDX: next_st.chan0_sel = pwdata[7:0]; // [R02]
        `DMA_CHANNEL1_REQUEST_SELECT_IDX: next_st.chan1_sel = pwdata[7:0]; // [R02]
        `ENDPOINT_DIRECTION_ENABLE_IDX: next_st.dir_enable = pwdata[7:0]; // [R05]
        default: next_st.prdata = st.prdata; // Status is read only
      endcase
    end
    // Per endpoint readiness and stale packet flush
    for (int i = 0; i < 4; i++) begin
      next_st.flush_oldest[i] = 1'b0;
      if (st.frame_deferred_ready && ep_iso[i]) begin
        // Data loaded in one frame goes out in the next
        if (sof_pulse) begin
          next_st.tx_ready[i] = tx_packet_loaded[i]; // [R07]
        end else begin
          next_st.tx_ready[i] = st.tx_ready[i] && tx_packet_loaded[i]; // [R07]
        end
        // Flag still set at frame start means two packets are queued
        next_st.flush_oldest[i] = sof_pulse && st.stale_packet_autoflush && tx_packet_loaded[i]; // [R08]
      end else begin
        next_st.tx_ready[i] = tx_packet_loaded[i]; // [R07]
      end
    end
    // Request routing to both DMA channels
    next_st.dma_req[0] = route(st.chan0_sel, st.dir_enable, ep_tx_write_req, ep_rx_read_req); // [R02] [R03]
    next_st.dma_req[1] = route(st.chan1_sel, st.dir_enable, ep_tx_write_req, ep_rx_read_req); // [R02] [R03]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Single register stage for the whole block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.chan0_sel <= `REQUEST_SELECT_RESET;
      st.chan1_sel <= `REQUEST_SELECT_RESET;
      st.dir_enable <= `ENDPOINT_DIRECTION_ENABLE_RESET; // [R05]
      st.frame_deferred_ready <= 1'(`ISOCHRONOUS_CONTROL_RESET >> `FRAME_DEFERRED_READY_BIT);
      st.stale_packet_autoflush <= 1'(`ISOCHRONOUS_CONTROL_RESET >> `STALE_PACKET_AUTOFLUSH_BIT); // [R01]
      st.tx_ready <= 4'h0;
      st.flush_oldest <= 4'h0;
      st.dma_req <= 2'b00;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.prdata <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign tx_ready = st.tx_ready;
  assign tx_flush_oldest = st.flush_oldest;
  assign dma_req = st.dma_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Write of the iso control word updates the flush enable
  a_autoflush_write: assert property ( // [R01]
    (psel && penable && pready && pwrite && paddr == 16'h0C20)
    |=> (st.stale_packet_autoflush == $past(pwdata[6])))
    else $error("autoflush bit not taken from write");

  // Channel 1 follows an enabled single selected request
  a_chan1_route: assert property ( // [R02]
    (st.chan1_sel == 8'h10 && st.dir_enable[0] && ep_rx_read_req[0]) |=> dma_req[1])
    else $error("channel 1 missed selected request");

  // Several select bits block the channel
  a_multi_sel_block: assert property ( // [R03]
    (st.chan0_sel == 8'h03) |=> !dma_req[0])
    else $error("channel 0 forwarded with two selects");

  // Bit 3 maps to endpoint 4 IN write request
  a_sel_bit_map: assert property ( // [R04]
    (st.chan0_sel == 8'h08 && st.dir_enable[7] && ep_tx_write_req[3]) ##1 (st.chan0_sel == 8'h08)
    |-> dma_req[0])
    else $error("bit 3 not routed to endpoint 4 write");

  // Enable register takes written data
  a_enable_write: assert property ( // [R05]
    (psel && penable && pready && pwrite && paddr == 16'h0C2C) |=> (st.dir_enable == $past(pwdata[7:0])))
    else $error("enable register not written");

  // Reserved iso control bits read zero
  a_iso_reserved: assert property ( // [R06]
    (psel && penable && !pready && paddr == 16'h0C20) |=> (pready && prdata[5:0] == 6'h00))
    else $error("reserved iso bits not zero");

  // Deferred ready cannot rise between frames
  a_defer_hold: assert property ( // [R07]
    (st.frame_deferred_ready && ep_iso[0] && !sof_pulse && !tx_ready[0]) |=> !tx_ready[0])
    else $error("deferred ready rose without frame start");

  // Without deferral readiness tracks the loaded flag
  a_nodefer_ready: assert property ( // [R07]
    (!st.frame_deferred_ready) |=> (tx_ready == $past(tx_packet_loaded)))
    else $error("ready not following loaded flag");

  // Frame start with a waiting packet flushes the oldest
  a_flush_on_sof: assert property ( // [R08]
    (sof_pulse && st.stale_packet_autoflush && st.frame_deferred_ready && ep_iso[0] && tx_packet_loaded[0])
    |=> tx_flush_oldest[0] ##1 !tx_flush_oldest[0])
    else $error("flush pulse missing or too long");

  // Disabled direction never reaches a channel
  a_enable_gate: assert property ( // [R10]
    (!st.dir_enable[1] && st.chan0_sel == 8'h01) |=> !dma_req[0])
    else $error("disabled endpoint request forwarded");

  // Flush enable moves only on a completed write of its word
  a_autoflush_hold: assert property ( // [R01]
    (!(psel && penable && pready && pwrite && paddr == 16'h0C20))
    |=> $stable(st.stale_packet_autoflush))
    else $error("autoflush bit changed without write");

  // Channel 0 follows an enabled single selected request
  a_chan0_route: assert property ( // [R02]
    (st.chan0_sel == 8'h01 && st.dir_enable[1] && ep_tx_write_req[0])
    |=> dma_req[0])
    else $error("channel 0 missed selected request");

  // Channel 0 select moves only on a completed write of its word
  a_chan0_hold: assert property ( // [R02]
    (!(psel && penable && pready && pwrite && paddr == 16'h0C24))
    |=> $stable(st.chan0_sel))
    else $error("channel 0 select changed without write");

  // Channel 1 select moves only on a completed write of its word
  a_chan1_hold: assert property ( // [R02]
    (!(psel && penable && pready && pwrite && paddr == 16'h0C28))
    |=> $stable(st.chan1_sel))
    else $error("channel 1 select changed without write");

  // Zero or several select bits leave channel 1 idle
  a_chan1_multi_block: assert property ( // [R03]
    (!one_hot(st.chan1_sel))
    |=> !dma_req[1])
    else $error("channel 1 forwarded without single select");

  // Bit 7 maps to endpoint 4 OUT read request
  a_rx_bit_map: assert property ( // [R04]
    (st.chan1_sel == 8'h80 && st.dir_enable[6] && ep_rx_read_req[3])
    |=> dma_req[1])
    else $error("bit 7 not routed to endpoint 4 read");

  // Enables move only on a completed write of their word
  a_enable_hold: assert property ( // [R05]
    (!(psel && penable && pready && pwrite && paddr == 16'h0C2C))
    |=> $stable(st.dir_enable))
    else $error("enable register changed without write");

  // Iso control reads back both flags over zero reserved bits
  a_iso_read_value: assert property ( // [R06]
    (psel && penable && !pready && !pwrite && paddr == 16'h0C20)
    |=> (prdata == {24'h000000, st.frame_deferred_ready, st.stale_packet_autoflush, 6'h00}))
    else $error("iso control read value wrong");

  // Only the low byte of read data ever carries a value
  a_upper_zero: assert property ( // [R06]
    pready
    |-> (prdata[31:8] == 24'h000000))
    else $error("read data upper bits not zero");

  // Deferred ready takes the loaded flag at frame start
  a_defer_release: assert property ( // [R07]
    (st.frame_deferred_ready && ep_iso[0] && sof_pulse)
    |=> (tx_ready[0] == $past(tx_packet_loaded[0])))
    else $error("deferred ready missed frame start");

  // A cleared loaded flag drops deferred ready at once
  a_defer_drop: assert property ( // [R07]
    (st.frame_deferred_ready && ep_iso[0] && !tx_packet_loaded[0])
    |=> !tx_ready[0])
    else $error("deferred ready kept without packet");

  // No flush unless both global iso bits are set
  a_no_flush_off: assert property ( // [R08]
    (!st.stale_packet_autoflush || !st.frame_deferred_ready)
    |=> (tx_flush_oldest == 4'h0))
    else $error("flush without both iso bits");

  // A non iso endpoint never flushes
  a_flush_non_iso: assert property ( // [R08]
    (!ep_iso[1])
    |=> !tx_flush_oldest[1])
    else $error("flush on non iso endpoint");

  // Disabled OUT direction never reaches channel 1
  a_enable_gate_rx: assert property ( // [R10]
    (!st.dir_enable[0] && st.chan1_sel == 8'h10)
    |=> !dma_req[1])
    else $error("disabled OUT request forwarded");

endmodule // usb_dma_select
`default_nettype wire

// ---- tb/frame_dma_partner.sv ----
// Model of the host frame timing seen by the block
`timescale 1ns/100ps
`default_nettype none

module frame_dma_partner #(
  parameter int FRAME_CYCLES = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic sof_pulse
);
  int cnt;
  // One start-of-frame pulse per frame, shortened so a run stays brief
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      sof_pulse <= 1'b0;
    end else begin
      sof_pulse <= (cnt == FRAME_CYCLES - 1);
      cnt <= (cnt == FRAME_CYCLES - 1) ? 0 : cnt + 1;
    end
  end
endmodule // frame_dma_partner
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench of the DMA request select block
`timescale 1ns/100ps
`default_nettype none
`include "usb_dma_select_regs.svh"

module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sof_pulse, last_err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] ep_iso, loaded, txw, rxr, tx_ready, flush;
  logic [1:0] dma_req;
  int err_count, cmp_count;

  usb_dma_select u_usb_dma_select (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sof_pulse(sof_pulse), .ep_iso(ep_iso), .tx_packet_loaded(loaded),
    .ep_tx_write_req(txw), .ep_rx_read_req(rxr), .tx_ready(tx_ready),
    .tx_flush_oldest(flush), .dma_req(dma_req));
  frame_dma_partner u_frame_dma_partner (.pclk(pclk), .presetn(presetn), .sof_pulse(sof_pulse));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounded wait for a level; running out ends the run
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((which ? sof_pulse : pready) !== 1'b1 && n < 100);
    if ((which ? sof_pulse : pready) !== 1'b1) begin
      err_count++;
      conclude();
    end
  endtask

  // One APB transfer; an idle edge first keeps psel from being set twice in a step
  task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    wait_for(0);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [13:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    check(q, {24'h000000, e});
  endtask

  // Request levels change on one edge; the routed request is registered once
  task automatic req(input logic [7:0] v, input logic [1:0] e);
    @(posedge pclk);
    {rxr, txw} <= v;
    repeat (2) @(posedge pclk);
    check(dma_req, e);
  endtask

  task automatic t_regs();
    rdchk(`ISOCHRONOUS_CONTROL_IDX, 8'h00);
    rdchk(`DMA_CHANNEL0_REQUEST_SELECT_IDX, 8'h00);
    rdchk(`DMA_CHANNEL1_REQUEST_SELECT_IDX, 8'h00);
    rdchk(`ENDPOINT_DIRECTION_ENABLE_IDX, 8'hFF);
    apb(1'b1, `ISOCHRONOUS_CONTROL_IDX, 8'hC0); // Reserved bits written as zero
    rdchk(`ISOCHRONOUS_CONTROL_IDX, 8'hC0);
    apb(1'b0, 14'h0300, 8'h00);
    check(last_err, 1'b1);
    check(q, 32'h00000000);
    apb(1'b1, `ISOCHRONOUS_CONTROL_IDX, 8'h00);
  endtask

  // Every select bit on both channels, then a double select on channel 0 and disabled directions
  task automatic t_route();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `DMA_CHANNEL0_REQUEST_SELECT_IDX, 8'h01 << i);
      apb(1'b1, `DMA_CHANNEL1_REQUEST_SELECT_IDX, 8'h80 >> i);
      req(8'h01 << i, 2'b01);
      req(8'h80 >> i, 2'b10);
      req(8'hFF, 2'b11);
    end
    apb(1'b1, `DMA_CHANNEL0_REQUEST_SELECT_IDX, 8'h03);
    req(8'hFF, 2'b10);
    apb(1'b1, `DMA_CHANNEL0_REQUEST_SELECT_IDX, 8'h01);
    apb(1'b1, `DMA_CHANNEL1_REQUEST_SELECT_IDX, 8'h10);
    apb(1'b1, `ENDPOINT_DIRECTION_ENABLE_IDX, 8'hFD);
    req(8'hFF, 2'b10);
    apb(1'b1, `ENDPOINT_DIRECTION_ENABLE_IDX, 8'hFE);
    req(8'hFF, 2'b01);
    rdchk(`SELECT_STATUS_IDX, 8'h10);
  endtask

  // Endpoint 1 isochronous: readiness held to the frame edge, stale packet dropped
  task automatic t_iso();
    apb(1'b1, `ISOCHRONOUS_CONTROL_IDX, 8'h80);
    wait_for(1);
    loaded <= 4'hF; // Packet loaded on all four endpoints, flag held set across frame starts
    repeat (3) @(posedge pclk);
    check(tx_ready, 4'hE);
    wait_for(1);
    @(posedge pclk);
    check(tx_ready, 4'hF);
    check(flush, 4'h0);
    apb(1'b1, `ISOCHRONOUS_CONTROL_IDX, 8'hC0);
    wait_for(1);
    @(posedge pclk);
    check(flush, 4'h1);
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    ep_iso = 4'h1;
    {loaded, txw, rxr} = 12'h000;
    err_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_route();
    t_iso();
    conclude();
  end
endmodule // tb
`default_nettype wire
